// ==== logic/mtr_resolver.sv ====
// Operation
// - Feature result bit 16 set for query functions 1 and 80000001h.
// - Attribute table always active; no disable control exists.
// - Reset slots with attribute bit clear match legacy two-bit typing.
// - Every translated access indexes one of eight slots by three bits.
// - Chosen slot type applies to the physical access.
// - Attribute, cache-off and write-thru bits captured from the used entry.
// - Weak uncached slot yields write-combining under write-combining range.
// - Attribute bit taken only from leaf or large-page entries.
// - Upper-level entries index only slots 0 to 3.
// - Upper-level resolved type governs fetch of next table level.
// - Range registers disabled means uncached range type.
// - Merge for uncached, weak uncached and write-combining slots.
// - Merge for write-protect, write-through and write-back slots.
// - No cross-processor consistency checking; software keeps tables equal.
// - Slot encodings 0,1,4,5,6,7; weak uncached overridable only.
// - Index is attribute, cache-off, write-thru; resets WB,WT,UC-,UC twice.
// - Unsupported encoding or reserved bits in a write raise a fault.
`timescale 1ns/10ps
`default_nettype none
module mtr_resolver
  import mtr_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic nrst, // Sync reset, active low
  input wire logic tbl_wr, // Table write strobe
  input wire logic [63:0] tbl_wdata, // Table write value
  output logic [63:0] tbl_rdata, // Table contents
  output logic fault_gp, // general_protection_fault pulse
  input wire logic query_valid, // feature_query_instr issued
  input wire logic [31:0] query_fn, // Query function
  output logic [31:0] feature_result_reg, // Query answer
  input wire logic xlat_valid, // Entry presented
  input wire logic [63:0] entry, // Table entry in use
  input wire mtr_level_t entry_level, // Which kind of entry
  input wire logic [2:0] range_type_register, // Range type
  input wire logic range_enable, // Range registers enabled
  output logic res_valid, // Result valid pulse
  output logic [2:0] res_slot, // Chosen slot index
  output logic [2:0] res_eff_type, // Effective type
  output logic res_for_walk // Result governs next-level fetch
);

  // ==========================================
  // Attribute lookup table
  logic [63:0] attribute_lookup_table;
  logic [63:0] next_table;
  logic next_fault;
  logic bad_write;

  always_comb
  begin
    bad_write = 1'b0;
    for (int i = 0; i < SLOT_N; i++)
      if (!mtr_type_ok(tbl_wdata[i*SLOT_W +: SLOT_W]))
        bad_write = 1'b1;
    next_table = attribute_lookup_table;
    next_fault = 1'b0;
    if (tbl_wr)
    begin
      if (bad_write)
        next_fault = 1'b1;
      else
        next_table = tbl_wdata;
    end
    if (!nrst)
    begin
      next_table = TABLE_RESET;
      next_fault = 1'b0;
    end
  end

  // No enable bit exists: lookup always uses the table
  // No cross-core consistency
  always_ff @(posedge clk)
  begin
    attribute_lookup_table <= next_table;
    fault_gp <= next_fault;
  end

  assign tbl_rdata = attribute_lookup_table;

  // ==========================================
  // Feature query
  logic [31:0] next_feat;

  always_comb
  begin
    next_feat = feature_result_reg;
    if (query_valid)
    begin
      next_feat = 32'h00000000;
      if (query_fn == FEAT_FN_BASIC || query_fn == FEAT_FN_EXT)
        next_feat[FEAT_BIT_POS] = 1'b1;
    end
    if (!nrst)
      next_feat = 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    feature_result_reg <= next_feat;
  end

  // ==========================================
  // Index formation
  logic attr_bit;
  logic page_cache_off_bit;
  logic page_write_thru_bit;
  logic [2:0] slot_idx;
  logic [2:0] slot_type;
  logic [2:0] range_eff;
  logic [2:0] merged;

  always_comb
  begin
    page_cache_off_bit = entry[CACHE_OFF_POS];
    page_write_thru_bit = entry[WRITE_THRU_POS];
    unique case (entry_level)
      MTR_LVL_LEAF: attr_bit = entry[LEAF_ATTR_POS];
      MTR_LVL_LARGE: attr_bit = entry[LARGE_ATTR_POS];
      default: attr_bit = 1'b0;
    endcase
    slot_idx = {attr_bit, page_cache_off_bit, page_write_thru_bit};
    slot_type = attribute_lookup_table[slot_idx*SLOT_W +: TYPE_W];
    range_eff = range_enable ? range_type_register
                             : MT_UNCACHED_STRICT;
  end

  mtr_combine u_combine (
    .slot_type(slot_type),
    .range_type(range_eff),
    .eff_type(merged)
  );

  // ==========================================
  // Result registers
  logic next_valid;
  logic [2:0] next_slot;
  logic [2:0] next_eff;
  logic next_walk;

  always_comb
  begin
    next_valid = xlat_valid;
    next_slot = res_slot;
    next_eff = res_eff_type;
    next_walk = res_for_walk;
    if (xlat_valid)
    begin
      next_slot = slot_idx;
      next_eff = merged;
      next_walk = (entry_level == MTR_LVL_UPPER);
    end
    if (!nrst)
    begin
      next_valid = 1'b0;
      next_slot = 3'h0;
      next_eff = MT_UNCACHED_STRICT;
      next_walk = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    res_valid <= next_valid;
    res_slot <= next_slot;
    res_eff_type <= next_eff;
    res_for_walk <= next_walk;
  end

  // ==========================================
  // Checks
  logic stored_ok;

  always_comb
  begin
    stored_ok = 1'b1;
    for (int i = 0; i < SLOT_N; i++)
      if (!mtr_type_ok(attribute_lookup_table[i*SLOT_W +: SLOT_W]))
        stored_ok = 1'b0;
  end

  a_reset_table: assert property (
    @(posedge clk)
    !nrst |=> tbl_rdata == TABLE_RESET && !res_valid && !fault_gp)
    else $error("reset state wrong");
  a_table_legal: assert property (
    @(posedge clk) disable iff (!nrst)
    stored_ok)
    else $error("table holds illegal slot");
  a_bad_write_fault: assert property (
    @(posedge clk) disable iff (!nrst)
    tbl_wr && bad_write |=> fault_gp && $stable(attribute_lookup_table))
    else $error("bad table write not faulted");
  a_fault_only_bad: assert property (
    @(posedge clk) disable iff (!nrst)
    !(tbl_wr && bad_write) |=> !fault_gp)
    else $error("fault without bad write");
  a_good_write: assert property (
    @(posedge clk) disable iff (!nrst)
    tbl_wr && !bad_write |=> tbl_rdata == $past(tbl_wdata) && !fault_gp)
    else $error("good table write not stored");
  a_table_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !tbl_wr |=> $stable(attribute_lookup_table))
    else $error("table changed without write");
  a_feature_bit: assert property (
    @(posedge clk) disable iff (!nrst)
    query_valid && (query_fn == FEAT_FN_BASIC || query_fn == FEAT_FN_EXT)
    |=> feature_result_reg[FEAT_BIT_POS])
    else $error("feature bit not reported");
  a_feature_other: assert property (
    @(posedge clk) disable iff (!nrst)
    query_valid && query_fn != FEAT_FN_BASIC && query_fn != FEAT_FN_EXT
    |=> !feature_result_reg[FEAT_BIT_POS])
    else $error("feature bit set for other function");
  a_feature_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !query_valid |=> $stable(feature_result_reg))
    else $error("feature result changed unasked");
  a_valid_pulse: assert property (
    @(posedge clk) disable iff (!nrst)
    !xlat_valid |=> !res_valid)
    else $error("result valid without lookup");
  a_walk_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid |=> res_valid && res_for_walk ==
    ($past(entry_level) == MTR_LVL_UPPER))
    else $error("walk flag wrong");
  a_leaf_index: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && entry_level == MTR_LVL_LEAF
    |=> res_slot == {$past(entry[7]), $past(entry[4]), $past(entry[3])})
    else $error("leaf index wrong");
  a_large_index: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && entry_level == MTR_LVL_LARGE
    |=> res_slot == {$past(entry[12]), $past(entry[4]), $past(entry[3])})
    else $error("large-page index wrong");
  a_upper_low_slot: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && entry_level == MTR_LVL_UPPER |=> !res_slot[2])
    else $error("upper entry chose high slot");
  a_upper_index: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && entry_level == MTR_LVL_UPPER
    |=> res_slot[1:0] == {$past(entry[4]), $past(entry[3])})
    else $error("upper index bits wrong");
  a_range_off_uc: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && !range_enable && slot_type == MT_WRITE_BACK
    |=> res_eff_type == MT_UNCACHED_STRICT)
    else $error("disabled range not uncached");
  a_wc_override: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_UNCACHED_WEAK && range_enable &&
    range_type_register == MT_WRITE_COMBINING
    |=> res_eff_type == MT_WRITE_COMBINING)
    else $error("weak uncached not overridden");
  a_wc_slot: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_WRITE_COMBINING
    |=> res_eff_type == MT_WRITE_COMBINING)
    else $error("write-combining slot lost");
  a_uc_slot: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_UNCACHED_STRICT &&
    range_eff != MT_UNCACHED_STRICT
    |=> res_eff_type == MT_CACHE_DISABLED_TYPE)
    else $error("uncached slot not cache-disabled");
  a_weak_uc_cd: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_UNCACHED_WEAK &&
    range_eff != MT_UNCACHED_STRICT && range_eff != MT_WRITE_COMBINING
    |=> res_eff_type == MT_CACHE_DISABLED_TYPE)
    else $error("weak uncached slot not cache-disabled");
  a_uc_range_wins: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && range_eff == MT_UNCACHED_STRICT &&
    slot_type != MT_WRITE_COMBINING
    |=> res_eff_type == MT_UNCACHED_STRICT)
    else $error("uncached range not uncached");
  a_wp_slot: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_WRITE_PROTECT &&
    (range_eff == MT_WRITE_PROTECT || range_eff == MT_WRITE_BACK)
    |=> res_eff_type == MT_WRITE_PROTECT)
    else $error("write-protect slot lost");
  a_wt_slot: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_WRITE_THROUGH &&
    (range_eff == MT_WRITE_THROUGH || range_eff == MT_WRITE_BACK)
    |=> res_eff_type == MT_WRITE_THROUGH)
    else $error("write-through slot lost");
  a_wb_follows: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && slot_type == MT_WRITE_BACK && range_enable
    |=> res_eff_type == $past(range_type_register))
    else $error("write-back slot not range type");
  a_slot_applied: assert property (
    @(posedge clk) disable iff (!nrst)
    xlat_valid && range_eff == MT_WRITE_BACK &&
    slot_type != MT_UNCACHED_STRICT && slot_type != MT_UNCACHED_WEAK
    |=> res_eff_type == $past(slot_type))
    else $error("slot type not applied");

endmodule : mtr_resolver
`default_nettype wire

// ==== logic/mtr_pkg.sv ====
`default_nettype none
package mtr_pkg;

  // ==========================================
  // Memory type encodings
  localparam logic [2:0] MT_UNCACHED_STRICT = 3'h0;
  localparam logic [2:0] MT_WRITE_COMBINING = 3'h1;
  localparam logic [2:0] MT_WRITE_THROUGH = 3'h4;
  localparam logic [2:0] MT_WRITE_PROTECT = 3'h5;
  localparam logic [2:0] MT_WRITE_BACK = 3'h6;
  localparam logic [2:0] MT_UNCACHED_WEAK = 3'h7;
  // Effective-only type, never stored in a slot
  localparam logic [2:0] MT_CACHE_DISABLED_TYPE = 3'h2;

  // ==========================================
  // Table layout
  localparam int SLOT_W = 8;
  localparam int SLOT_N = 8;
  localparam int TYPE_W = 3;
  localparam logic [63:0] TABLE_RESET = 64'h0007040600070406;

  // ==========================================
  // Feature report
  localparam int FEAT_BIT_POS = 16;
  localparam logic [31:0] FEAT_FN_BASIC = 32'h00000001;
  localparam logic [31:0] FEAT_FN_EXT = 32'h80000001;

  // ==========================================
  // Entry levels and bit positions
  typedef enum logic [1:0] {
    MTR_LVL_LEAF = 2'h0,
    MTR_LVL_LARGE = 2'h1,
    MTR_LVL_UPPER = 2'h2
  } mtr_level_t;
  localparam int LEAF_ATTR_POS = 7;
  localparam int LARGE_ATTR_POS = 12;
  localparam int CACHE_OFF_POS = 4;
  localparam int WRITE_THRU_POS = 3;

  // ==========================================
  // Slot encoding legal?
  function automatic logic mtr_type_ok(input logic [7:0] s);
    mtr_type_ok = (s[7:3] == 5'h00) && (s[2:1] != 2'h1);
  endfunction : mtr_type_ok

endpackage : mtr_pkg
`default_nettype wire

// ==== logic/mtr_combine.sv ====
`timescale 1ns/10ps
`default_nettype none
module mtr_combine
  import mtr_pkg::*;
(
  input wire logic [2:0] slot_type, // Type from chosen slot
  input wire logic [2:0] range_type, // Range register type
  output logic [2:0] eff_type // Effective type
);

  // ==========================================
  // Merge table
  always_comb
  begin
    eff_type = MT_CACHE_DISABLED_TYPE;
    unique case (slot_type)
      MT_UNCACHED_STRICT:
        eff_type = (range_type == MT_UNCACHED_STRICT) ?
          MT_UNCACHED_STRICT : MT_CACHE_DISABLED_TYPE;
      MT_UNCACHED_WEAK:
      begin
        if (range_type == MT_UNCACHED_STRICT)
          eff_type = MT_UNCACHED_STRICT;
        else if (range_type == MT_WRITE_COMBINING)
          eff_type = MT_WRITE_COMBINING;
        else
          eff_type = MT_CACHE_DISABLED_TYPE;
      end
      MT_WRITE_COMBINING:
        eff_type = MT_WRITE_COMBINING;
      MT_WRITE_PROTECT:
      begin
        if (range_type == MT_UNCACHED_STRICT)
          eff_type = MT_UNCACHED_STRICT;
        else if (range_type == MT_WRITE_PROTECT ||
                 range_type == MT_WRITE_BACK)
          eff_type = MT_WRITE_PROTECT;
        else
          eff_type = MT_CACHE_DISABLED_TYPE;
      end
      MT_WRITE_THROUGH:
      begin
        if (range_type == MT_UNCACHED_STRICT)
          eff_type = MT_UNCACHED_STRICT;
        else if (range_type == MT_WRITE_THROUGH ||
                 range_type == MT_WRITE_BACK)
          eff_type = MT_WRITE_THROUGH;
        else
          eff_type = MT_CACHE_DISABLED_TYPE;
      end
      MT_WRITE_BACK:
        eff_type = range_type;
      default:
        eff_type = MT_CACHE_DISABLED_TYPE;
    endcase
  end

endmodule : mtr_combine
`default_nettype wire

// ==== verif/mtr_walker_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mtr_walker_model
  import mtr_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic req, // Lookup wanted
  input wire logic [63:0] req_entry, // Entry to present
  input wire mtr_level_t req_level, // Entry kind
  output logic xlat_valid, // Lookup strobe
  output logic [63:0] entry, // Entry driven
  output mtr_level_t entry_level // Level driven
);
  initial
  begin
    xlat_valid = 1'b0;
    entry = 64'h0;
    entry_level = MTR_LVL_UPPER;
  end
  // One entry per lookup, each page one type only
  // Idle entry flips every cycle so stale bits never pass
  always @(posedge clk)
  begin
    xlat_valid <= req;
    entry <= req ? req_entry : ~entry;
    entry_level <= req ? req_level : MTR_LVL_UPPER;
  end
endmodule : mtr_walker_model
`default_nettype wire

// ==== verif/memory_type_resolver_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module memory_type_resolver_tb
  import mtr_pkg::*;
;
  localparam logic [63:0] NEW_TAB = 64'h0006070605040100;
  logic clk, nrst, tbl_wr, query_valid, range_enable, req, xlat_valid;
  logic fault_gp, res_valid, res_for_walk;
  logic [63:0] tbl_wdata, tbl_rdata, entry, req_entry;
  logic [31:0] query_fn, feature_result_reg;
  logic [2:0] range_type_register, res_slot, res_eff_type;
  mtr_level_t entry_level, req_level;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [2:0] rngs [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic [2:0] old_ty [8] = '{3'h6, 3'h4, 3'h7, 3'h0, 3'h6, 3'h4, 3'h7, 3'h0};
  logic [2:0] new_ty [8] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h6, 3'h0};

  mtr_walker_model model_u (.clk(clk), .req(req), .req_entry(req_entry),
    .req_level(req_level), .xlat_valid(xlat_valid), .entry(entry),
    .entry_level(entry_level));
  mtr_resolver dut_u (.clk(clk), .nrst(nrst), .tbl_wr(tbl_wr),
    .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .fault_gp(fault_gp),
    .query_valid(query_valid), .query_fn(query_fn),
    .feature_result_reg(feature_result_reg), .xlat_valid(xlat_valid),
    .entry(entry), .entry_level(entry_level),
    .range_type_register(range_type_register), .range_enable(range_enable),
    .res_valid(res_valid), .res_slot(res_slot), .res_eff_type(res_eff_type),
    .res_for_walk(res_for_walk));

  // ==========================================
  // Helpers
  task results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [2:0] eff(input logic [2:0] s, input logic [2:0] r);
    logic u;
    u = (r == MT_UNCACHED_STRICT);
    case (s)
      MT_UNCACHED_STRICT: eff = u ? r : MT_CACHE_DISABLED_TYPE;
      MT_UNCACHED_WEAK: eff = (u || r == MT_WRITE_COMBINING) ? r : 3'h2;
      MT_WRITE_COMBINING: eff = MT_WRITE_COMBINING;
      MT_WRITE_PROTECT: eff = u ? r : (r == 3'h5 || r == 3'h6) ? s : 3'h2;
      MT_WRITE_THROUGH: eff = u ? r : (r == 3'h4 || r == 3'h6) ? s : 3'h2;
      default: eff = r;
    endcase
  endfunction : eff

  function automatic logic [63:0] mk(input int i, input mtr_level_t lv);
    logic [2:0] b;
    b = 3'(i);
    mk = 64'h0;
    mk[WRITE_THRU_POS] = b[0];
    mk[CACHE_OFF_POS] = b[1];
    mk[LEAF_ATTR_POS] = (lv == MTR_LVL_LEAF) ? b[2] : ~b[2];
    mk[LARGE_ATTR_POS] = (lv == MTR_LVL_LARGE) ? b[2] : ~b[2];
  endfunction : mk

  task automatic look(input logic [63:0] e, input mtr_level_t lv,
    input logic [2:0] rt, input logic en, input logic [2:0] sl,
    input logic [2:0] ty);
    @(posedge clk);
    req <= 1'b1;
    req_entry <= e;
    req_level <= lv;
    range_type_register <= rt;
    range_enable <= en;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1;
    chk("res_valid", 64'h1, res_valid);
    chk("res_slot", sl, res_slot);
    chk("res_eff_type", ty, res_eff_type);
    chk("res_for_walk", lv == MTR_LVL_UPPER, res_for_walk);
  endtask : look

  task automatic sweep(input logic [2:0] ty [8], input int n,
    input mtr_level_t lv, input logic en);
    logic [2:0] sl;
    foreach (rngs[r])
      for (int i = 0; i < n; i++)
      begin
        sl = (lv == MTR_LVL_UPPER) ? {1'b0, 2'(i)} : 3'(i);
        look(mk(i, lv), lv, rngs[r], en, sl,
          eff(ty[sl], en ? rngs[r] : MT_UNCACHED_STRICT));
      end
  endtask : sweep

  task automatic wr(input logic [63:0] v, input logic f, input logic [63:0] t);
    @(posedge clk);
    tbl_wr <= 1'b1;
    tbl_wdata <= v;
    @(posedge clk);
    tbl_wr <= 1'b0;
    #1;
    chk("fault_gp", f, fault_gp);
    chk("tbl_rdata", t, tbl_rdata);
    @(posedge clk);
    #1;
    chk("fault_gp_end", 64'h0, fault_gp);
  endtask : wr

  // ==========================================
  // Scenarios
  task automatic t_query;
    logic [31:0] fns [4];
    fns = '{FEAT_FN_BASIC, FEAT_FN_EXT, 32'h00000002, 32'h80000000};
    foreach (fns[i])
    begin
      @(posedge clk);
      query_valid <= 1'b1;
      query_fn <= fns[i];
      @(posedge clk);
      query_valid <= 1'b0;
      #1;
      chk("feature", 64'(i < 2) << FEAT_BIT_POS, feature_result_reg);
    end
  endtask : t_query

  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("tbl_mid_reset", TABLE_RESET, tbl_rdata);
    chk("slot_mid_reset", 64'h0, res_slot);
    chk("valid_mid_reset", 64'h0, res_valid);
    sweep(old_ty, 4, MTR_LVL_LEAF, 1'b1);
  endtask : t_reset

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    {nrst, tbl_wr, query_valid, range_enable, req} = 5'h00;
    tbl_wdata = 64'h0;
    query_fn = 32'h0;
    range_type_register = 3'h0;
    req_entry = 64'h0;
    req_level = MTR_LVL_LEAF;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("tbl_reset", TABLE_RESET, tbl_rdata);
    chk("res_valid_reset", 64'h0, res_valid);
    t_query();
    sweep(old_ty, 4, MTR_LVL_LEAF, 1'b1);
    wr(64'h0000000000000002, 1'b1, TABLE_RESET);
    wr(64'h0800000000000000, 1'b1, TABLE_RESET);
    // No lookup in flight while the table changes
    wr(NEW_TAB, 1'b0, NEW_TAB);
    sweep(new_ty, 8, MTR_LVL_LEAF, 1'b1);
    sweep(new_ty, 8, MTR_LVL_LARGE, 1'b1);
    sweep(new_ty, 8, MTR_LVL_UPPER, 1'b1);
    sweep(new_ty, 8, MTR_LVL_LEAF, 1'b0);
    t_reset();
    results();
  end
endmodule : memory_type_resolver_tb
`default_nettype wire
